//--- hw/dtx_pkg.sv
// Package: register map, control fields, timing constants of the transceiver host port
// Behaviour
// [RQ1] Burst and equal pause last 51 ms
// [RQ2] Set transmitter ready after burst and pause
// [RQ3] Progress mode doubles burst, pause to 102 ms
// [RQ4] Progress plus burst mode: transmit only, no decode
// [RQ5] Host times odd lengths with burst off
// [RQ6] Single tone from low or high group
// [RQ7] Register access completes without wait states
// [RQ8] Select low: write tone code, read digit
// [RQ9] Select high: write control, read status
// [RQ10] Receive register holds last validated digit
// [RQ11] Written tone code selects generated tone pair
// [RQ12] Bank toggle steers one write to word B
// [RQ13] Host initialises control registers at program start
// [RQ14] Event pin is open drain, low active
// [RQ15] Tone output enable gates all transmit tones
// [RQ16] Progress mode drives received tone square wave
// [RQ17] Event pin low on digit or ready
// [RQ18] Word B: column/row, single, test, burst bits
// [RQ19] Burst bit low enables burst mode
// [RQ20] Empty flag set at pause end, cleared
// [RQ21] Event flag follows empty or full flags
// [RQ22] Single tone: column when high, row low
// [RQ23] Control steering starts at word A
// [RQ24] Durations counted from free running clock
package dtx_pkg;
  localparam logic       SEL_DATA       = 1'b0;
  localparam logic       SEL_CTRL       = 1'b1;
  // Control word A fields
  localparam int         CA_TONE_EN     = 0;
  localparam int         CA_PROGRESS    = 1;
  localparam int         CA_IRQ_EN      = 2;
  localparam int         CA_BANK        = 3;
  // Control word B fields
  localparam int         CB_BURST_OFF   = 0;
  localparam int         CB_TEST        = 1;
  localparam int         CB_SINGLE      = 2;
  localparam int         CB_COLUMN      = 3;
  // Status fields
  localparam int         ST_EVENT       = 0;
  localparam int         ST_TX_EMPTY    = 1;
  localparam int         ST_RX_FULL     = 2;
  localparam int         ST_DSTEER      = 3;
  localparam logic [3:0] CTRL_RESET     = 4'h0;
  localparam logic [3:0] CTRLB_RESET    = 4'h1;
  // Timing
  localparam int         CLK_HZ         = 100_000_000;
  localparam int         BURST_MS       = 51;
  localparam int         BURST_CYC      = BURST_MS * (CLK_HZ / 1000);
  localparam int         CNT_W          = 24;
  typedef enum logic [1:0] {DTX_IDLE, DTX_BURST, DTX_PAUSE} dtx_state_t;
endpackage

//--- hw/dtx_host_port.sv
// Module: host register port and burst timing of the tone transceiver
`timescale 1ns/1ns
`default_nettype none
module dtx_host_port
  import dtx_pkg::*;
#(
  parameter int BURST_CYCLES = BURST_CYC
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Host bus pins, asynchronous
  input  wire logic       register_select_line,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic [3:0] data_in,
  output logic      [3:0] data_out,
  output logic            data_oe,
  // Receiver side, same clock
  input  wire logic       rx_digit_valid,
  input  wire logic [3:0] rx_digit,
  input  wire logic       rx_steer_present,
  input  wire logic       rx_progress_tone,
  // Tone generator controls
  output logic      [3:0] tone_pair_code,
  output logic            tone_on,
  output logic            tone_single,
  output logic            tone_column,
  output logic            rx_decode_en,
  output logic            test_mode,
  // Open-drain event pin
  input  wire logic       event_or_tone_pin_in,
  output logic            event_or_tone_pin_out,
  output logic            event_or_tone_pin_oe
);
  // ==========================================================
  // Pin synchronisers
  logic [2:0] s1_reg, s2_reg, s3_reg;
  logic [3:0] d1_reg, d2_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= 3'h7;
      s2_reg <= 3'h7;
      s3_reg <= 3'h7;
      d1_reg <= 4'h0;
      d2_reg <= 4'h0;
    end
    else
    begin
      s1_reg <= {register_select_line, wr_n, rd_n};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      d1_reg <= data_in;
      d2_reg <= d1_reg;
    end
  end
  wire sel      = s2_reg[2];
  wire wr_act   = ~s2_reg[1];
  wire rd_act   = ~s2_reg[0];
  // Write acts on the strobe's rising edge, read effects on the end
  wire wr_done  = ~s3_reg[1] & s2_reg[1];
  wire rd_done  = ~s3_reg[0] & s2_reg[0];
  wire wr_sel   = s3_reg[2];
  wire rd_sel   = s3_reg[2];
  wire wr_data  = wr_done & (wr_sel == SEL_DATA);                     // RQ8
  wire wr_ctrl  = wr_done & (wr_sel == SEL_CTRL);                     // RQ9
  wire rd_stat  = rd_done & (rd_sel == SEL_CTRL);                     // RQ9

  // ==========================================================
  // Registers
  logic [3:0] ca_reg, cb_reg, tx_reg, rx_reg;
  logic       bank_reg;
  logic       empty_reg, full_reg;
  wire        wr_b      = wr_ctrl & bank_reg;                         // RQ12
  wire        wr_a      = wr_ctrl & ~bank_reg;
  wire        burst_on  = ~cb_reg[CB_BURST_OFF];                      // RQ19
  wire        progress  = ca_reg[CA_PROGRESS];
  wire        decode_en = ~progress;                                  // RQ4 RQ16
  wire        rx_take   = rx_digit_valid & decode_en;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ca_reg   <= CTRL_RESET;
      cb_reg   <= CTRLB_RESET;
      tx_reg   <= 4'h0;
      rx_reg   <= 4'h0;
      bank_reg <= 1'b0;                                               // RQ23
    end
    else
    begin
      if (wr_a)
        ca_reg <= d2_reg;
      if (wr_b)
        cb_reg <= d2_reg;                                             // RQ18
      if (wr_ctrl)
        bank_reg <= wr_a & d2_reg[CA_BANK];                           // RQ12
      if (wr_data)
        tx_reg <= d2_reg;                                             // RQ11
      if (rx_take)
        rx_reg <= rx_digit;                                           // RQ10
    end
  end

  // ==========================================================
  // Burst timer on free running clock
  dtx_state_t st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  wire  [CNT_W:0]   dur  = progress ? {CNT_W'(BURST_CYCLES), 1'b0}                 // RQ3
                                    : {1'b0, CNT_W'(BURST_CYCLES)};                // RQ1
  wire  [CNT_W:0]   last = dur - 1'b1;
  wire              at_end = ({1'b0, cnt_reg} >= last);
  wire              pause_end = (st_reg == DTX_PAUSE) & at_end;       // RQ2
  always_comb
  begin
    st_next  = st_reg;
    cnt_next = cnt_reg + 1'b1;                                        // RQ24
    case (st_reg)
      DTX_IDLE:
      begin
        cnt_next = '0;
        if (wr_data & burst_on)
          st_next = DTX_BURST;
      end
      DTX_BURST:
        if (at_end)
        begin
          st_next  = DTX_PAUSE;
          cnt_next = '0;
        end
      DTX_PAUSE:
        if (at_end)
        begin
          st_next  = DTX_IDLE;
          cnt_next = '0;
        end
      default:
        st_next = DTX_IDLE;
    endcase
    if (!burst_on)
      st_next = DTX_IDLE;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg  <= DTX_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // Status flags, set wins over read clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      empty_reg <= 1'b0;
      full_reg  <= 1'b0;
    end
    else
    begin
      empty_reg <= burst_on & (pause_end | (empty_reg & ~rd_stat));   // RQ20
      full_reg  <= rx_take | (full_reg & ~rd_stat);                   // RQ21
    end
  end
  wire       event_flag = empty_reg | full_reg;                       // RQ21
  wire [3:0] status     = {~rx_steer_present, full_reg, empty_reg, event_flag};

  // ==========================================================
  // Read data and outputs, registered one clock after the synced strobe
  logic [3:0] dout_reg;
  logic       oe_reg;
  logic       pin_low_reg;
  wire  [3:0] rd_val = (sel == SEL_CTRL) ? status : rx_reg;           // RQ8 RQ9
  wire  irq_en   = ca_reg[CA_IRQ_EN];
  wire  pin_low  = irq_en & (progress ? rx_progress_tone              // RQ16
                   : (cb_reg[CB_TEST] ? ~rx_steer_present
                   : (full_reg | (burst_on & empty_reg))));           // RQ17
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dout_reg    <= 4'h0;
      oe_reg      <= 1'b0;
      pin_low_reg <= 1'b0;
    end
    else
    begin
      dout_reg    <= rd_val;                                          // RQ7
      oe_reg      <= rd_act & ~wr_act;
      pin_low_reg <= pin_low;
    end
  end
  assign data_out              = dout_reg;
  assign data_oe               = oe_reg;
  assign tone_pair_code        = tx_reg;                              // RQ11
  // Tone enable gates every mode; burst mode adds burst window
  assign tone_on               = ca_reg[CA_TONE_EN]                   // RQ15
                                 & (~burst_on | (st_reg == DTX_BURST)); // RQ19
  assign tone_single           = cb_reg[CB_SINGLE];                   // RQ6 RQ22
  assign tone_column           = cb_reg[CB_COLUMN];                   // RQ22
  assign rx_decode_en          = decode_en;                           // RQ4
  assign test_mode             = cb_reg[CB_TEST];
  assign event_or_tone_pin_out = 1'b0;                                // RQ14
  assign event_or_tone_pin_oe  = pin_low_reg;                         // RQ14
  wire unused_ok = event_or_tone_pin_in;
endmodule
`default_nettype wire

//--- verif/dtx_host_port_properties.sv
// Pin checks of the host port
`timescale 1ns/1ns
`default_nettype none
module dtx_host_port_properties #(parameter int BURST_CYCLES = 20)
(
  // Clock, reset, bus
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       register_select_line,
  input wire logic       rd_n,
  input wire logic       rx_steer_present,
  // Watched outputs
  input wire logic [3:0] data_out,
  input wire logic       data_oe,
  input wire logic [3:0] tone_pair_code,
  input wire logic       tone_on,
  input wire logic       tone_single,
  input wire logic       event_or_tone_pin_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  pin_open_a: assert property (event_or_tone_pin_out == 1'b0)
    else $error("pin driven");
  oe_rise_a: assert property ($fell(rd_n) |-> ##[2:5] data_oe)
    else $error("late read data");
  oe_idle_a: assert property (rd_n [*6] |-> !data_oe)
    else $error("oe without read");
  oe_cause_a: assert property ($rose(data_oe) |-> !$past(rd_n, 2))
    else $error("oe early");
  code_sel_a: assert property ($changed(tone_pair_code) |-> !register_select_line)
    else $error("code on ctrl");
  ctrl_sel_a: assert property ($changed(tone_single) |-> register_select_line)
    else $error("ctrl on data");
  steer_bit_a: assert property ((!rd_n && register_select_line) [*5]
    |-> data_out[3] == !rx_steer_present) else $error("status b3");
  tone_hold_a: assert property ($rose(tone_on) |-> tone_on [*4])
    else $error("tone glitch");
  reset_quiet_a: assert property (disable iff (1'b0) rst
    |-> tone_pair_code == 4'h0 && !tone_on && !data_oe) else $error("reset");
endmodule
`default_nettype wire

//--- verif/dtx_host_model.sv
// Host bus model for register cycles
`timescale 1ns/1ns
`default_nettype none
module dtx_host_model
(
  // Clock and read data
  input  wire logic       clk,
  input  wire logic [3:0] data_out,
  // Host driven pins
  output logic            register_select_line = 1'b0,
  output logic            wr_n = 1'b1,
  output logic            rd_n = 1'b1,
  output logic      [3:0] data_in = 4'h0
);
  task automatic cyc(input logic s, input logic w, input logic [3:0] d, output logic [3:0] q);
    @(posedge clk);
    register_select_line <= s;
    data_in <= d;
    repeat (4) @(posedge clk);
    if (w) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    q = data_out;
    @(posedge clk);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (6) @(posedge clk);
    data_in <= ~d;
  endtask
endmodule
`default_nettype wire

//--- verif/dtx_host_port_tb_top.sv
// Testbench of the host port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: %h vs %h", $time, a, b); end end
module dtx_host_port_tb_top;
  localparam int          BP = 20;
  localparam logic [15:0] ROWS [10] = '{16'h0550, 16'h1850, 16'h1d5c, 16'h115d, 16'h185c,
                                        16'h1352, 16'h0aa2, 16'h18a2, 16'h10a0, 16'h15a0};
  logic                   clk = 1'b0;
  logic                   rst = 1'b0;
  logic                   dv = 1'b0;
  logic                   steer = 1'b0;
  logic                   cpt = 1'b0;
  logic [3:0]             dg = 4'h0;
  logic [3:0]             q;
  wire logic              sel, wr_n, rd_n, doe, ton, sgl, col, dec, tst, pout, poe;
  wire logic [3:0]        din, dout, code;
  int                     n;
  int                     run = 0;
  int                     last_on = 0;
  int                     bad_count = 0;
  int                     cmp_count = 0;
  dtx_host_model dtx_host_model_i (.clk(clk), .data_out(dout), .register_select_line(sel),
    .wr_n(wr_n), .rd_n(rd_n), .data_in(din));
  dtx_host_port #(.BURST_CYCLES(BP)) dtx_host_port_i (.clk(clk), .rst(rst),
    .register_select_line(sel), .wr_n(wr_n), .rd_n(rd_n), .data_in(din), .data_out(dout),
    .data_oe(doe), .rx_digit_valid(dv), .rx_digit(dg), .rx_steer_present(steer),
    .rx_progress_tone(cpt), .tone_pair_code(code), .tone_on(ton), .tone_single(sgl),
    .tone_column(col), .rx_decode_en(dec), .test_mode(tst), .event_or_tone_pin_in(!poe),
    .event_or_tone_pin_out(pout), .event_or_tone_pin_oe(poe));
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Length of the last tone burst
  always @(negedge clk)
  begin
    if (ton) run = run + 1;
    else if (run != 0)
    begin
      last_on = run;
      run = 0;
    end
  end
  task automatic close_out;
    $display("Mismatches %0d of %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic xfer(input logic s, input logic w, input logic [3:0] d);
    dtx_host_model_i.cyc(s, w, d, q);
  endtask
  task automatic waitv(input logic k);
    for (n = 0; (k ? poe : !ton) !== 1'b1; n++)
    begin
      @(negedge clk);
      if (n > 300)
      begin
        bad_count++;
        close_out;
      end
    end
  endtask
  task automatic digit(input logic [3:0] d);
    dg <= d;
    dv <= 1'b1;
    @(posedge clk);
    dv <= 1'b0;
  endtask
  initial
  begin
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK({code, col, sgl, tst, ton}, 8'h00)
    foreach (ROWS[i])
    begin
      xfer(ROWS[i][12], 1'b1, ROWS[i][11:8]);
      `CHK({code, col, sgl, tst, ton}, ROWS[i][7:0])
    end
    xfer(1'b0, 1'b1, 4'h7);
    `CHK(ton, 1'b1)
    waitv(1'b0);
    waitv(1'b1);
    `CHK(n >= BP && n <= BP + 3, 1'b1)
    `CHK(last_on, BP)
    xfer(1'b1, 1'b0, 4'h0);
    `CHK(q, 4'hb)
    xfer(1'b1, 1'b0, 4'h0);
    `CHK({q, poe}, 5'h10)
    digit(4'h6);
    xfer(1'b0, 1'b0, 4'h0);
    `CHK({q, poe}, 5'h0d)
    xfer(1'b1, 1'b0, 4'h0);
    `CHK(q, 4'hd)
    xfer(1'b1, 1'b1, 4'h3);
    `CHK(dec, 1'b0)
    digit(4'h9);
    xfer(1'b0, 1'b0, 4'h0);
    `CHK(q, 4'h6)
    xfer(1'b0, 1'b1, 4'h2);
    waitv(1'b0);
    repeat (2 * BP + 4) @(posedge clk);
    `CHK(last_on, 2 * BP)
    xfer(1'b1, 1'b1, 4'h7);
    cpt <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK(poe, 1'b1)
    @(posedge clk);
    cpt <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK(poe, 1'b0)
    close_out;
  end
endmodule
bind dtx_host_port dtx_host_port_properties #(.BURST_CYCLES(BURST_CYCLES)) chk_i (.clk(clk),
  .rst(rst), .register_select_line(register_select_line), .rd_n(rd_n), .data_out(data_out),
  .rx_steer_present(rx_steer_present), .data_oe(data_oe), .tone_pair_code(tone_pair_code),
  .tone_on(tone_on), .tone_single(tone_single), .event_or_tone_pin_out(event_or_tone_pin_out));
`default_nettype wire
